// [src/touch_measure_seq.sv]
// Measurement sequencer of a capacitive touch sensing unit.
`timescale 1ns/100ps

module touch_measure_seq
  import touch_seq_pkg::*;
#(
  parameter int NCH = 16
) (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic [7:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output      logic [31:0]           rdata,
  input  wire logic                  ext_trigger,
  input  wire logic                  osc_tick,
  output      pin_drive_s [NCH-1:0]  pins,
  output      logic                  osc_enable,
  output      logic                  channel_setting_request,
  output      logic                  result_read_request,
  output      logic                  measure_end_request
);

  localparam int CHW = $clog2(NCH);

  // ********************************************************************
  // Storage.
  // ********************************************************************
  status_e              state_reg;
  logic [CTRL_W-1:0]    ctrl_reg;
  logic [NCH-1:0]       chan_en_reg;
  logic [NCH-1:0]       tx_mask_reg;
  logic [CHW-1:0]       single_ch_reg;
  logic [PERIOD_W-1:0]  set_a_reg;
  logic [BDIV_W-1:0]    set_b_reg;
  logic                 set_a_done_reg;
  logic                 set_b_done_reg;
  logic [RESULT_W-1:0]  result_reg;
  logic [RESULT_W-1:0]  count_reg;
  logic                 pending_reg;
  logic                 phase_reg;
  logic [CHW-1:0]       chan_reg;
  logic                 pins_active_reg;
  logic [1:0]           wait_reg;
  logic [15:0]          timer_reg;
  logic [BDIV_W-1:0]    base_cnt_reg;
  logic [1:0]           quad_reg;

  // ********************************************************************
  // Decodes.
  // ********************************************************************
  logic wr_ctrl;
  logic abort;
  logic base_tick;
  logic mutual;
  logic [NCH-1:0] rx_cand;
  logic [NCH-1:0] tx_meas;
  logic           found;
  logic [CHW-1:0] found_ch;
  logic           trig_ok;

  assign wr_ctrl   = wr && (addr == CTRL_ADDR);
  assign abort     = wr_ctrl && !wdata[START_BIT] && wdata[INIT_BIT];
  assign base_tick = (base_cnt_reg == set_b_reg);
  assign mutual    = ctrl_reg[MUTUAL_BIT];
  // Receive candidates exclude transmit-designated pins in both methods.
  assign rx_cand   = chan_en_reg & ~tx_mask_reg;
  // In the mutual method every enabled transmit pin pairs with the target.
  assign tx_meas   = chan_en_reg & tx_mask_reg;
  // External trigger waits for a pulse; software trigger goes at once.
  assign trig_ok   = ctrl_reg[START_BIT] && (!ctrl_reg[EXTRIG_BIT] || ext_trigger);

  // In scan mode pick the lowest eligible channel at or above the current one; otherwise the single channel.
  always_comb begin
    found    = 1'b0;
    found_ch = '0;
    if (!ctrl_reg[SCAN_BIT]) begin
      found    = rx_cand[single_ch_reg];
      found_ch = single_ch_reg;
    end else begin
      for (int i = NCH - 1; i >= 0; i--) begin
        if (rx_cand[i] && (CHW'(i) >= chan_reg)) begin
          found    = 1'b1;
          found_ch = CHW'(i);
        end
      end
    end
    // The mutual method cannot measure without a transmit pin.
    if (mutual && (tx_meas == '0)) begin
      found = 1'b0;
    end
  end

  // ********************************************************************
  // Base clock: divides the operating clock by the setting b value plus one.
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (!rstn || base_tick) begin
      base_cnt_reg <= '0;
    end else begin
      base_cnt_reg <= base_cnt_reg + 1'b1;
    end
  end

  // Quarter phase of the drive pulse; restarts when the pins go active.
  always_ff @(posedge clock) begin
    if (!rstn || !pins_active_reg) begin
      quad_reg <= 2'h1;
    end else if (base_tick) begin
      quad_reg <= quad_reg + 2'h1;
    end
  end

  // ********************************************************************
  // Software registers.
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_reg <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata[CTRL_W-1:0];
        ctrl_reg[INIT_BIT] <= 1'b0;  // The init bit acts only on the write.
      end else if (state_reg == ST_IDLE && trig_ok && !ctrl_reg[EXTRIG_BIT]) begin
        ctrl_reg[START_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      chan_en_reg   <= '0;
      tx_mask_reg   <= '0;
      single_ch_reg <= '0;
      set_a_reg     <= '0;
      set_b_reg     <= '0;
    end else if (wr) begin
      if (addr == CHAN_EN_ADDR) chan_en_reg <= wdata[NCH-1:0];
      if (addr == TX_MASK_ADDR) tx_mask_reg <= wdata[NCH-1:0];
      if (addr == SINGLE_CH_ADDR) single_ch_reg <= wdata[CHW-1:0];
      if (addr == SET_A_ADDR) set_a_reg <= wdata[PERIOD_W-1:0];
      if (addr == SET_B_ADDR) set_b_reg <= wdata[BDIV_W-1:0];
    end
  end

  // Both setting writes are tracked; the request of a new channel rearms them.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      set_a_done_reg <= 1'b0;
      set_b_done_reg <= 1'b0;
    end else begin
      if (wr && addr == SET_A_ADDR) begin
        set_a_done_reg <= 1'b1;
      end else if (channel_setting_request || state_reg == ST_IDLE) begin
        set_a_done_reg <= 1'b0;
      end
      if (wr && addr == SET_B_ADDR) begin
        set_b_done_reg <= 1'b1;
      end else if (channel_setting_request || state_reg == ST_IDLE) begin
        set_b_done_reg <= 1'b0;
      end
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata <= ZERO_WORD;
    end else if (rd) begin
      rdata <= ZERO_WORD;
      case (addr)
        CTRL_ADDR:      rdata[CTRL_W-1:0]   <= ctrl_reg;
        CHAN_EN_ADDR:   rdata[NCH-1:0]      <= chan_en_reg;
        TX_MASK_ADDR:   rdata[NCH-1:0]      <= tx_mask_reg;
        SINGLE_CH_ADDR: rdata[CHW-1:0]      <= single_ch_reg;
        SET_A_ADDR:     rdata[PERIOD_W-1:0] <= set_a_reg;
        SET_B_ADDR:     rdata[BDIV_W-1:0]   <= set_b_reg;
        RESULT_ADDR:    rdata[RESULT_W-1:0] <= result_reg;
        STATUS_ADDR: begin
          rdata[2:0]                    <= status_num(state_reg);
          rdata[ST_PHASE_BIT]           <= phase_reg;
          rdata[ST_PEND_BIT]            <= pending_reg;
          rdata[ST_CH_LSB +: CHW]       <= chan_reg;
        end
        default:        rdata <= ZERO_WORD;
      endcase
    end
  end

  function automatic logic [2:0] status_num(input status_e s);
    case (s)
      ST_IDLE:   status_num = 3'h0;
      ST_SELECT: status_num = 3'h1;
      ST_SETUP:  status_num = 3'h2;
      ST_STAB:   status_num = 3'h3;
      ST_MEAS:   status_num = 3'h4;
      ST_END:    status_num = 3'h5;
      default:   status_num = 3'h0;
    endcase
  endfunction

  // ********************************************************************
  // Status counter.
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (!rstn || abort) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (trig_ok) state_reg <= ST_SELECT;
        end
        ST_SELECT: begin
          if (!found) begin
            state_reg <= ST_IDLE;
          end else if (!phase_reg) begin
            state_reg <= ST_SETUP;
          end else if (pins_active_reg && base_tick) begin
            state_reg <= ST_STAB;
          end
        end
        ST_SETUP: begin
          if (pins_active_reg && base_tick) state_reg <= ST_STAB;
        end
        ST_STAB: begin
          // A result still unread holds off the next measurement.
          if (timer_reg == 16'(STAB_CYCLES - 1) && !pending_reg) begin
            state_reg <= ST_MEAS;
          end
        end
        ST_MEAS: begin
          if (timer_reg == set_a_reg) state_reg <= ST_END;
        end
        ST_END: begin
          if (mutual && !phase_reg) begin
            state_reg <= ST_SELECT;
          end else if (ctrl_reg[SCAN_BIT] && chan_reg != CHW'(NCH - 1)) begin
            state_reg <= ST_SELECT;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Stabilisation and measurement timer, zero on entry to ST_STAB and ST_MEAS.
  always_ff @(posedge clock) begin
    if (!rstn || state_reg == ST_SETUP || state_reg == ST_SELECT) begin
      timer_reg <= '0;
    end else if (state_reg == ST_STAB) begin
      if (timer_reg != 16'(STAB_CYCLES - 1)) timer_reg <= timer_reg + 16'h0001;
      else if (!pending_reg) timer_reg <= '0;
    end else if (state_reg == ST_MEAS) begin
      timer_reg <= timer_reg + 16'h0001;
    end else begin
      timer_reg <= '0;
    end
  end

  // Channel pointer and mutual phase flag.
  always_ff @(posedge clock) begin
    if (!rstn || abort || state_reg == ST_IDLE) begin
      chan_reg  <= '0;
      phase_reg <= 1'b0;
    end else if (state_reg == ST_SELECT && found) begin
      chan_reg <= found_ch;
    end else if (state_reg == ST_END) begin
      if (mutual && !phase_reg) begin
        phase_reg <= 1'b1;
      end else begin
        phase_reg <= 1'b0;
        chan_reg  <= (chan_reg == CHW'(NCH - 1)) ? chan_reg : chan_reg + 1'b1;
      end
    end
  end

  // Pins run ahead of the unit by one base tick.
  always_ff @(posedge clock) begin
    if (!rstn || abort) begin
      pins_active_reg <= 1'b0;
      wait_reg        <= '0;
    end else begin
      case (state_reg)
        ST_SETUP: begin
          if (set_a_done_reg && set_b_done_reg) pins_active_reg <= 1'b1;
        end
        ST_SELECT: begin
          if (found && phase_reg && !pins_active_reg && base_tick) begin
            if (wait_reg == 2'(SECOND_PIN_TICKS - 1)) pins_active_reg <= 1'b1;
            else wait_reg <= wait_reg + 2'h1;
          end
        end
        ST_STAB, ST_MEAS: pins_active_reg <= 1'b1;
        default: begin
          pins_active_reg <= 1'b0;
          wait_reg        <= '0;
        end
      endcase
    end
  end

  // ********************************************************************
  // Result counter and pending flag.
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (!rstn || state_reg != ST_MEAS) begin
      count_reg <= '0;
    end else if (osc_tick) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Hardware set wins over a read in the same cycle.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      result_reg  <= '0;
      pending_reg <= 1'b0;
    end else if (state_reg == ST_MEAS && timer_reg == set_a_reg) begin
      result_reg  <= osc_tick ? count_reg + 1'b1 : count_reg;
      pending_reg <= 1'b1;
    end else if (rd && addr == RESULT_ADDR) begin
      result_reg  <= '0;
      pending_reg <= 1'b0;
    end
  end

  // ********************************************************************
  // Requests, each one cycle long.
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      channel_setting_request <= 1'b0;
      result_read_request     <= 1'b0;
      measure_end_request     <= 1'b0;
    end else begin
      channel_setting_request <= !abort && state_reg == ST_SELECT && found
                                 && !phase_reg;
      result_read_request     <= !abort && state_reg == ST_MEAS
                                 && timer_reg == set_a_reg;
      measure_end_request     <= !abort && ((state_reg == ST_SELECT && !found)
                                 || (state_reg == ST_END && !(mutual && !phase_reg)
                                 && !(ctrl_reg[SCAN_BIT]
                                 && chan_reg != CHW'(NCH - 1))));
    end
  end

  // ********************************************************************
  // Pin drive.
  // ********************************************************************
  logic drive_wave;
  logic tx_wave;
  // Drive high in quarters 2 and 3; the transmit edge lands entering quarter 3.
  assign drive_wave = quad_reg[1];
  assign tx_wave    = ((quad_reg == 2'h3) || (quad_reg == 2'h0)) ^ phase_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= !abort && (state_reg == ST_STAB || state_reg == ST_MEAS);
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < NCH; i++) begin
      // Default: sensor output off, normal output driving low.
      pins[i].sensor_oe  <= 1'b0;
      pins[i].sensor_out <= 1'b0;
      pins[i].gpio_oe    <= 1'b1;
      pins[i].gpio_out   <= 1'b0;
      if (rstn && !abort && pins_active_reg) begin
        if (!tx_mask_reg[i] && chan_en_reg[i] && CHW'(i) == chan_reg) begin
          pins[i].sensor_oe  <= 1'b1;
          pins[i].sensor_out <= drive_wave;
          pins[i].gpio_oe    <= 1'b0;
        end else if (tx_meas[i]) begin
          // Self method: shield pulse only, never measured.
          if (ctrl_reg[TXSEL_BIT]) begin
            pins[i].sensor_oe  <= 1'b1;
            pins[i].sensor_out <= mutual ? tx_wave : drive_wave;
            pins[i].gpio_oe    <= 1'b0;
          end else begin
            pins[i].gpio_out   <= mutual ? tx_wave : drive_wave;
          end
        end
      end
    end
  end

endmodule // touch_measure_seq

// [src/touch_seq_pkg.sv]
// Package holding constants and types of the touch measurement sequencer.
package touch_seq_pkg;

  // ********************************************************************
  // Register map (byte addresses) and field positions.
  // ********************************************************************
  localparam logic [7:0] CTRL_ADDR      = 8'h00;
  localparam logic [7:0] CHAN_EN_ADDR   = 8'h04;
  localparam logic [7:0] TX_MASK_ADDR   = 8'h08;
  localparam logic [7:0] SINGLE_CH_ADDR = 8'h0C;
  localparam logic [7:0] SET_A_ADDR     = 8'h10;
  localparam logic [7:0] SET_B_ADDR     = 8'h14;
  localparam logic [7:0] RESULT_ADDR    = 8'h18;
  localparam logic [7:0] STATUS_ADDR    = 8'h1C;

  localparam int START_BIT  = 0;
  localparam int INIT_BIT   = 1;
  localparam int SCAN_BIT   = 2;
  localparam int MUTUAL_BIT = 3;
  localparam int TXSEL_BIT  = 4;
  localparam int EXTRIG_BIT = 5;
  localparam int CTRL_W     = 6;

  localparam int PERIOD_W   = 16;
  localparam int BDIV_W     = 8;
  localparam int RESULT_W   = 16;

  localparam int ST_PHASE_BIT = 3;
  localparam int ST_PEND_BIT  = 4;
  localparam int ST_CH_LSB    = 8;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ********************************************************************
  // Timing.
  // ********************************************************************
  localparam int CLK_MHZ      = 250;
  localparam int STAB_TIME_NS = 1000;
  localparam int STAB_CYCLES  = (STAB_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SECOND_PIN_TICKS = 2;

  // ********************************************************************
  // Status counter, Gray coded along 0-1-2-3-4-5.
  // ********************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SELECT = 3'h1,
    ST_SETUP  = 3'h3,
    ST_STAB   = 3'h2,
    ST_MEAS   = 3'h6,
    ST_END    = 3'h7
  } status_e;

  // Drive of one sensor pin: dedicated sensor output and normal output.
  typedef struct packed {
    logic sensor_oe;
    logic sensor_out;
    logic gpio_oe;
    logic gpio_out;
  } pin_drive_s;

endpackage

// [tb/touch_sensor_model.sv]
// Behavioural model of the sense oscillator behind the touch electrodes.
`timescale 1ns/100ps
module touch_sensor_model (
  input  wire logic clock,
  input  wire logic osc_enable,
  output logic      osc_tick
);
  logic phase_reg = 1'b0;
  initial osc_tick = 1'b0;
  // A stopped oscillator gives no count pulses; a running one ticks every other cycle.
  always @(posedge clock) begin
    phase_reg <= osc_enable & ~phase_reg;
    osc_tick  <= osc_enable & phase_reg;
  end
endmodule // touch_sensor_model

// [tb/touch_seq_checker.sv]
// Port checker of the touch measurement sequencer.
`timescale 1ns/100ps
module touch_seq_checker
  import touch_seq_pkg::*;
#(
  parameter int NCH = 16
) (
  input wire logic                 clock,
  input wire logic                 rstn,
  input wire logic [7:0]           addr,
  input wire logic [31:0]          wdata,
  input wire logic                 wr,
  input wire pin_drive_s [NCH-1:0] pins,
  input wire logic                 osc_enable,
  input wire logic                 channel_setting_request,
  input wire logic                 result_read_request,
  input wire logic                 measure_end_request
);
  logic [NCH-1:0] drive_vec;
  logic           all_low;
  logic           got_a_reg;

  // ******************************************************************
  // Helper logic.
  // ******************************************************************
  // Sensor drivers in use, and the parked state where every pin is driven low.
  always_comb begin
    all_low = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      drive_vec[i] = pins[i].sensor_oe;
      if (pins[i] != pin_drive_s'(4'h2)) begin
        all_low = 1'b0;
      end
    end
  end

  // Remembers the first setting write, so the second one can be tied to the pins.
  always_ff @(posedge clock) begin
    if (!rstn || (wr && addr == SET_B_ADDR)) begin
      got_a_reg <= 1'b0;
    end else if (wr && addr == SET_A_ADDR) begin
      got_a_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence start_write;
    wr && addr == CTRL_ADDR && wdata[START_BIT] && !wdata[INIT_BIT] && !wdata[EXTRIG_BIT];
  endsequence

  // ******************************************************************
  // Assertions.
  // ******************************************************************
  csr_pulse_a: assert property (channel_setting_request |=> !channel_setting_request)
    else $error("channel setting request is longer than one cycle");
  rrr_pulse_a: assert property ($rose(result_read_request) |=> $fell(result_read_request))
    else $error("result read request is longer than one cycle");
  end_pulse_a: assert property (measure_end_request |=> !measure_end_request)
    else $error("measure end request is longer than one cycle");
  start_req_a: assert property (start_write and (all_low && !osc_enable) |->
    ##[1:6] (channel_setting_request || measure_end_request))
    else $error("start write raised no request");
  abort_idle_a: assert property ((wr && addr == CTRL_ADDR && !wdata[START_BIT]
    && wdata[INIT_BIT]) |-> ##[2:6] (all_low && !osc_enable))
    else $error("abort did not park the pins");
  set_drive_a: assert property ((wr && addr == SET_B_ADDR && got_a_reg) |->
    ##[1:3] (drive_vec != '0))
    else $error("setting writes did not start the sensor drive");
  end_park_a: assert property (measure_end_request |-> ##2 (all_low && !osc_enable)[*2])
    else $error("pins not parked after measure end");
  setreq_osc_a: assert property (channel_setting_request |=> !osc_enable)
    else $error("oscillator on during channel setting");
  read_release_a: assert property (result_read_request |-> ##[1:2] (drive_vec == '0))
    else $error("sensor drive kept after measurement end");

  cover property (channel_setting_request);
  cover property (result_read_request ##[1:20] channel_setting_request);
  cover property (measure_end_request);
  cover property (wr && addr == CTRL_ADDR && wdata[INIT_BIT]);
endmodule // touch_seq_checker

bind touch_measure_seq touch_seq_checker #(.NCH(NCH)) i_touch_seq_checker (
  .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .pins(pins),
  .osc_enable(osc_enable), .channel_setting_request(channel_setting_request),
  .result_read_request(result_read_request), .measure_end_request(measure_end_request));

// [tb/test_capacitive_touch_measure_seq.sv]
// Self-checking testbench of the touch measurement sequencer.
`timescale 1ns/100ps
module test_capacitive_touch_measure_seq
  import touch_seq_pkg::*;
();
  localparam int          NCH   = 4;
  localparam logic [31:0] SET_A = 32'h0000_0003;
  logic                 clock;
  logic                 rstn;
  logic [7:0]           addr;
  logic [31:0]          wdata;
  logic                 wr;
  logic                 rd;
  logic [31:0]          rdata;
  logic                 ext_trigger;
  logic                 osc_tick;
  pin_drive_s [NCH-1:0] pins;
  logic                 osc_enable;
  logic                 csr;
  logic                 rrr;
  logic                 mer;
  int                   errors = 0;
  int                   samples_checked = 0;
  int                   cnt [3] = '{0, 0, 0};
  int                   tx_edges [2] = '{0, 0};
  logic                 tx_prev = 1'b0;

  touch_measure_seq #(.NCH(NCH)) i_touch_measure_seq (.clock(clock), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_trigger(ext_trigger),
    .osc_tick(osc_tick), .pins(pins), .osc_enable(osc_enable),
    .channel_setting_request(csr), .result_read_request(rrr), .measure_end_request(mer));
  touch_sensor_model i_touch_sensor_model (.clock(clock), .osc_enable(osc_enable),
    .osc_tick(osc_tick));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Counts of the three request pulses: setting, result and end.
  always @(posedge clock) begin
    cnt[0] <= cnt[0] + int'(csr === 1'b1);
    cnt[1] <= cnt[1] + int'(rrr === 1'b1);
    cnt[2] <= cnt[2] + int'(mer === 1'b1);
  end

  // Pin 0 transmit edges inside the high phase of receive pin 1: [0] rising, [1] falling.
  always @(posedge clock) begin
    tx_prev <= pins[0].sensor_out;
    if (pins[1].sensor_oe && pins[1].sensor_out && pins[0].sensor_oe
        && tx_prev !== pins[0].sensor_out) begin
      tx_edges[tx_prev] <= tx_edges[tx_prev] + 1;
    end
  end

  // ******************************************************************
  // Shared tasks.
  // ******************************************************************
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    samples_checked++;
    if (seen !== expd) begin
      errors++;
      $display("Error at %0t ns: seen %h, expected %h", $time, seen, expd);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Waits until a pulse counter reaches a target; the bound keeps a hang short.
  task automatic wait_evt(input int sel, input int target, output int cycles);
    cycles = 0;
    while (cnt[sel] < target) begin
      @(posedge clock);
      #1;
      cycles++;
      if (cycles > 3000) begin
        errors++;
        $display("Error at %0t ns: request %0d never came", $time, sel);
        complete_run();
      end
    end
  endtask

  task automatic check_idle();
    for (int i = 0; i < NCH; i++) begin
      check({28'h0, pins[i]}, 32'h2);
    end
    check({31'h0, osc_enable}, 32'h0);
  endtask

  // One measurement pass from the setting writes to the result request.
  task automatic run_channel(input int rx, input int tx, input int idle, input bit late,
    input bit txsel);
    logic [31:0] d;
    int          r;
    int          n;
    r = cnt[1];
    bus_write(SET_A_ADDR, SET_A);
    bus_write(SET_B_ADDR, ZERO_WORD);
    repeat (4) @(posedge clock);
    #1;
    check({30'h0, pins[rx].sensor_oe, pins[rx].gpio_oe}, 32'h2);
    check({30'h0, pins[tx].sensor_oe, pins[tx].gpio_oe}, {30'h0, txsel, !txsel});
    check({31'h0, pins[idle].sensor_oe}, 32'h0);
    check({31'h0, osc_enable}, 32'h1);
    if (late) begin
      repeat (300) @(posedge clock);
      check(cnt[1], r);
      bus_read(RESULT_ADDR, d);
    end
    wait_evt(1, r + 1, n);
    if (!late) begin
      check({31'h0, n >= STAB_CYCLES && n <= STAB_CYCLES + SET_A + 8}, 32'h1);
    end
  endtask

  // ******************************************************************
  // Scenarios.
  // ******************************************************************
  task automatic test_reset();
    logic [31:0] d;
    @(posedge clock);
    #1;
    check_idle();
    bus_read(STATUS_ADDR, d);
    check(d, ZERO_WORD);
    bus_read(8'h20, d);
    check(d, ZERO_WORD);
  endtask

  task automatic test_single();
    logic [31:0] d;
    int          c;
    int          e;
    int          n;
    c = cnt[0];
    e = cnt[2];
    bus_write(CHAN_EN_ADDR, 32'h0000_0006);
    bus_write(SINGLE_CH_ADDR, 32'h0000_0002);
    bus_write(CTRL_ADDR, 32'h0000_0001);
    wait_evt(0, c + 1, n);
    bus_read(STATUS_ADDR, d);
    check({24'h0, d[15:8]}, 32'h2);
    check({29'h0, d[2:0]}, 32'h2);
    run_channel(2, 2, 3, 1'b0, 1'b1);
    // The sense model ticks every other cycle, so a four-cycle period counts two.
    bus_read(RESULT_ADDR, d);
    check(d, 32'h2);
    wait_evt(2, e + 1, n);
    bus_read(RESULT_ADDR, d);
    check(d, ZERO_WORD);
    check(cnt[0] - c, 1);
    bus_read(CTRL_ADDR, d);
    check({31'h0, d[START_BIT]}, 32'h0);
    check_idle();
  endtask

  task automatic test_multi();
    logic [31:0] d;
    int          c;
    int          e;
    int          n;
    c = cnt[0];
    e = cnt[2];
    bus_write(CHAN_EN_ADDR, 32'h0000_000B);
    bus_write(TX_MASK_ADDR, 32'h0000_0001);
    bus_write(CTRL_ADDR, 32'h0000_0005);
    wait_evt(0, c + 1, n);
    bus_read(STATUS_ADDR, d);
    check({24'h0, d[15:8]}, 32'h1);
    run_channel(1, 0, 3, 1'b0, 1'b0);
    wait_evt(0, c + 2, n);
    bus_read(STATUS_ADDR, d);
    check({24'h0, d[15:8]}, 32'h3);
    run_channel(3, 0, 1, 1'b1, 1'b0);
    bus_read(RESULT_ADDR, d);
    wait_evt(2, e + 1, n);
    check(cnt[0] - c, 2);
  endtask

  task automatic test_mutual();
    logic [31:0] d;
    int          c;
    int          r;
    int          e;
    int          n;
    c = cnt[0];
    r = cnt[1];
    e = cnt[2];
    bus_write(CHAN_EN_ADDR, 32'h0000_0003);
    bus_write(TX_MASK_ADDR, 32'h0000_0001);
    bus_write(SINGLE_CH_ADDR, 32'h0000_0001);
    bus_write(CTRL_ADDR, 32'h0000_0019);
    wait_evt(0, c + 1, n);
    bus_read(STATUS_ADDR, d);
    check({31'h0, d[ST_PHASE_BIT]}, 32'h0);
    run_channel(1, 0, 2, 1'b0, 1'b1);
    check({31'h0, tx_edges[0] > 0 && tx_edges[1] == 0}, 32'h1);
    bus_read(STATUS_ADDR, d);
    check({31'h0, d[ST_PHASE_BIT]}, 32'h1);
    bus_read(RESULT_ADDR, d);
    wait_evt(1, r + 2, n);
    check({31'h0, tx_edges[1] > 0}, 32'h1);
    bus_read(RESULT_ADDR, d);
    wait_evt(2, e + 1, n);
    check(cnt[0] - c, 1);
  endtask

  task automatic test_trigger_abort();
    logic [31:0] d;
    int          c;
    int          n;
    c = cnt[0];
    bus_write(CTRL_ADDR, 32'h0000_0021);
    repeat (20) @(posedge clock);
    check(cnt[0], c);
    bus_read(CTRL_ADDR, d);
    check({31'h0, d[START_BIT]}, 32'h1);
    @(posedge clock);
    ext_trigger <= 1'b1;
    @(posedge clock);
    ext_trigger <= 1'b0;
    wait_evt(0, c + 1, n);
    bus_write(CTRL_ADDR, 32'h0000_0002);
    repeat (4) @(posedge clock);
    bus_read(STATUS_ADDR, d);
    check({29'h0, d[2:0]}, 32'h0);
    check_idle();
  endtask

  initial begin
    rstn        = 1'b0;
    addr        = 8'h00;
    wdata       = ZERO_WORD;
    wr          = 1'b0;
    rd          = 1'b0;
    ext_trigger = 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    test_reset();
    test_single();
    test_multi();
    test_mutual();
    test_trigger_abort();
    complete_run();
  end
endmodule // test_capacitive_touch_measure_seq
